/* src/pcm_highway_pkg.sv */
// Package: constants and carrier types for the highway channel coder.
// Assumes one system clock; highway pins are sampled as synchronous inputs.
package pcm_highway_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Configuration port map
   localparam logic [7:0]  ADDR_CTRL    = 8'h00;
   localparam logic [7:0]  ADDR_RX_SLOT = 8'h01;
   localparam logic [7:0]  ADDR_TX_SLOT = 8'h02;
   localparam logic [7:0]  ADDR_STATUS  = 8'h03;
   localparam logic [7:0]  ADDR_RX_LO   = 8'h04;
   localparam logic [7:0]  ADDR_RX_HI   = 8'h05;
   localparam logic [7:0]  CTRL_RESET   = 8'h00;
   localparam logic [6:0]  SLOT_RESET   = 7'h00;

   ////////////////////////////////////////////////////////////////////////
   // Coding constants
   localparam logic [7:0]  ABI_MASK     = 8'h55;
   localparam logic [15:0] MU_BIAS      = 16'h0084;
   localparam logic [15:0] A_HALF_STEP  = 16'h0008;
   localparam logic [15:0] A_SEG_BASE   = 16'h0100;
   localparam int          SIG_DET1     = 7;
   localparam int          SIG_DET2     = 6;
   localparam int          SIG_CLOCK_FAILURE_FLAG    = 2;
   localparam int          GCI_RATE_KHZ = 2048;
   localparam logic [9:0]  CNT_MAX      = 10'h3FF;
   localparam logic [6:0]  SLOT_ONE     = 7'h01;

   ////////////////////////////////////////////////////////////////////////
   // Types
   // Field order puts double_clock_enable at bit 0 of the control register
   typedef struct packed {
      logic mux_sel;
      logic gci_mode;
      logic master_clock_source_sel;
      logic linear;
      logic mu_law;
      logic robbed_bit_enable;
      logic highway_signaling_enable;
      logic double_clock_enable;
   } ctrl_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } cfg_req_t;

   typedef enum logic [1:0] {
      FS_IDLE = 2'b00,
      FS_ONE  = 2'b01,
      FS_TWO  = 2'b10,
      FS_LONG = 2'b11
   } fs_len_t;

endpackage : pcm_highway_pkg

/* src/pcm_highway_coder.sv */
// Receive/transmit coding and framing for one four-channel group.
// Assumes bit clock, frame syncs and data pins are synchronous to clk_in
// and that clk_in is well above twice the highway bit clock.
//
// Operation
// - Receive the GCI channel chosen by the two channel-select pins.
// - Voice bytes go to the expander; monitor and control bytes go out.
// - GCI frame sync marks channel 0; downstream rate is fixed.
// - Expand per A-law or mu-law; A-law uses alternate bit inversion.
// - Linear samples are 16-bit two's complement, sign first, two slots.
// - Double clock off: data shifts at the bit clock rate.
// - Double clock on: data shifts at half the bit clock rate.
// - Divide-by-two lives only in the slot assigner.
// - Master clock select one routes bit clock to the DSP clock.
// - Signaling on: companded sample slot, then a signaling slot.
// - Signaling byte: bit7 detector one, bit6 detector two/mux, bit2 fail.
// - Signaling MSB follows the data LSB with no gap.
// - Signaling slot is driven even while the channel is inactive.
// - Robbed-bit mode acts only in mu-law and on receive.
// - Transmit is unchanged and sends full bytes in every slot.
// - Robbed frame: drop received LSB, use half its weight instead.
// - Robbed frame: enabled, mu-law, PCM mode, sync two clocks, previous not.
// - Sync sampled on falling edges; two highs then a low is two clocks.
// - Half-LSB substitution only on the channel's valid receive slots.
// - Frame sync marks receive slot 0; slots are counted from it.
`timescale 1ns/10ps
module pcm_highway_coder (
   // Clock and reset
   input  wire logic                      clk_in,
   input  wire logic                      rst_in,
   // Configuration port
   input  wire pcm_highway_pkg::cfg_req_t cfg_req_in,
   output logic [7:0]                     cfg_rdata_out,
   // Clocks
   input  wire logic                      bit_clk_in,
   input  wire logic                      mclk_in,
   output logic                           dsp_clk_out,
   // Highway pins
   input  wire logic                      pcm_frame_sync_in,
   input  wire logic                      pcm_rx_data_in,
   input  wire logic                      gci_frame_sync_in,
   input  wire logic                      downstream_line_in,
   input  wire logic                      gci_chan_sel_low_in,
   input  wire logic                      gci_chan_sel_high_in,
   output logic                           tx_data_out,
   output logic                           tx_enable_out,
   // Channel side
   input  wire logic [15:0]               tx_code_in,
   input  wire logic                      channel_active_in,
   input  wire logic                      detector_input_first_in,
   input  wire logic                      detector_input_second_in,
   input  wire logic                      detector_input_muxed_in,
   input  wire logic                      clock_failure_flag_in,
   output logic [15:0]                    rx_linear_out,
   output logic                           rx_valid_out,
   output logic                           rx_voice_sel_out,
   output logic [7:0]                     monitor_byte_out,
   output logic                           monitor_strobe_out,
   output logic [7:0]                     signal_control_byte_out,
   output logic                           signal_control_strobe_out,
   output logic                           robbed_frame_out
);
   import pcm_highway_pkg::*;

   typedef struct packed {
      ctrl_t       ctrl;
      logic [6:0]  rx_slot;
      logic [6:0]  tx_slot;
      logic        clk_prev;
      logic        phase;
      logic        framed;
      logic [9:0]  bit_cnt;
      fs_len_t     fs_len;
      logic        prev_two;
      logic        robbed;
      logic [7:0]  rx_sh;
      logic [7:0]  lin_hi;
      logic [15:0] rx_lin;
      logic        rx_valid;
      logic        rx_voice;
      logic [7:0]  mon;
      logic        mon_stb;
      logic [7:0]  scb;
      logic        sc_stb;
      logic [15:0] tx_word;
      logic        tx_data;
      logic        tx_en;
      logic        dsp_clk;
      logic [7:0]  rdata;
   } state_t;

   state_t s_q;
   state_t s_d;

   ////////////////////////////////////////////////////////////////////////
   // Expander: companded byte to 16-bit linear
   function automatic logic [15:0] expand(input logic [7:0] code,
                                          input logic       mu,
                                          input logic       half_lsb);
      logic [7:0]  c;
      logic [4:0]  m2;
      logic [15:0] t;
      logic [15:0] mag;
      logic        neg;
      c   = 8'h00;
      m2  = 5'h00;
      t   = 16'h0000;
      mag = 16'h0000;
      neg = 1'b0;
      if (mu) begin
         c   = ~code;
         m2  = half_lsb ? {c[3:1], 2'b01} : {c[3:0], 1'b0};
         t   = (({9'h000, m2, 2'b00}) + MU_BIAS) << c[6:4];
         mag = t - MU_BIAS;
         neg = c[7];
      end else begin
         c   = code ^ ABI_MASK;
         t   = {8'h00, c[3:0], 4'h0} + A_HALF_STEP;
         if (c[6:4] != 3'h0) begin
            mag = (t + A_SEG_BASE) << (c[6:4] - 3'h1);
         end else begin
            mag = t;
         end
         neg = ~c[7];
      end
      expand = neg ? (16'h0000 - mag) : mag;
   endfunction : expand

   ////////////////////////////////////////////////////////////////////////
   // Next-state logic
   logic       fall;
   logic       start;
   logic       shift;
   logic       din;
   logic       fs_s;
   logic [9:0] pos;
   logic [7:0] rx_byte;
   logic [6:0] slot;
   logic [6:0] tslot;
   logic [3:0] tsel;
   logic [7:0] sig_byte;
   logic [7:0] tx_comp;
   logic       two;

   always_comb begin
      s_d      = s_q;
      fs_s     = s_q.ctrl.gci_mode ? gci_frame_sync_in : pcm_frame_sync_in;
      din      = s_q.ctrl.gci_mode ? downstream_line_in : pcm_rx_data_in;
      fall     = s_q.clk_prev & ~bit_clk_in;
      start    = fall & fs_s & (s_q.fs_len == FS_IDLE);
      // Divider only gates the slot assigner's shift events
      shift    = start | (fall & s_q.framed &
                  (~s_q.ctrl.double_clock_enable | s_q.ctrl.gci_mode |
                   s_q.phase));
      pos      = start ? 10'h000 :
                 ((s_q.bit_cnt == CNT_MAX) ? CNT_MAX : s_q.bit_cnt + 10'h001);
      rx_byte  = {s_q.rx_sh[6:0], din};
      slot     = pos[9:3];
      tslot    = slot - s_q.tx_slot;
      tsel     = {tslot[0], pos[2:0]};
      two      = (s_q.fs_len == FS_TWO);
      sig_byte = 8'h00;
      sig_byte[SIG_DET1]  = detector_input_first_in;
      sig_byte[SIG_DET2]  = s_q.ctrl.mux_sel ? detector_input_muxed_in :
                            detector_input_second_in;
      sig_byte[SIG_CLOCK_FAILURE_FLAG] = clock_failure_flag_in;
      tx_comp  = s_q.ctrl.mu_law ? tx_code_in[7:0] :
                 (tx_code_in[7:0] ^ ABI_MASK);

      s_d.clk_prev  = bit_clk_in;
      s_d.rx_valid  = 1'b0;
      s_d.mon_stb   = 1'b0;
      s_d.sc_stb    = 1'b0;
      s_d.rdata     = 8'h00;
      // Master clock select picks the DSP clock source; no division here
      s_d.dsp_clk   = s_q.ctrl.master_clock_source_sel ? bit_clk_in :
                      mclk_in;

      // Frame sync length, judged on the first low falling sample
      if (fall) begin
         s_d.phase = start ? 1'b0 : ~s_q.phase;
         if (fs_s) begin
            case (s_q.fs_len)
               FS_IDLE: s_d.fs_len = FS_ONE;
               FS_ONE:  s_d.fs_len = FS_TWO;
               FS_TWO:  s_d.fs_len = FS_LONG;
               FS_LONG: s_d.fs_len = FS_LONG;
               default: s_d.fs_len = FS_IDLE;
            endcase
         end else if (s_q.fs_len != FS_IDLE) begin
            s_d.fs_len   = FS_IDLE;
            s_d.prev_two = two;
            s_d.robbed   = s_q.ctrl.robbed_bit_enable & s_q.ctrl.mu_law &
                           ~s_q.ctrl.gci_mode & two & ~s_q.prev_two;
         end
      end
      if (start) begin
         s_d.framed = 1'b1;
         s_d.robbed = 1'b0;
      end

      if (shift) begin
         s_d.bit_cnt = pos;
         s_d.rx_sh   = rx_byte;
         // Receive side, one byte per slot end
         if (pos[2:0] == 3'h7) begin
            if (s_q.ctrl.gci_mode) begin
               if (slot[6:5] == 2'b00 &&
                   slot[4:2] == {1'b0, gci_chan_sel_high_in,
                                 gci_chan_sel_low_in}) begin
                  case (slot[1:0])
                     2'b00, 2'b01: begin
                        s_d.rx_lin   = expand(rx_byte, s_q.ctrl.mu_law, 1'b0);
                        s_d.rx_valid = 1'b1;
                        s_d.rx_voice = slot[0];
                     end
                     2'b10: begin
                        s_d.mon     = rx_byte;
                        s_d.mon_stb = 1'b1;
                     end
                     default: begin
                        s_d.scb    = rx_byte;
                        s_d.sc_stb = 1'b1;
                     end
                  endcase
               end
            end else if (slot == s_q.rx_slot) begin
               if (s_q.ctrl.linear) begin
                  s_d.lin_hi = rx_byte;
               end else begin
                  s_d.rx_lin   = expand(rx_byte, s_q.ctrl.mu_law,
                                        s_q.robbed);
                  s_d.rx_valid = 1'b1;
                  s_d.rx_voice = 1'b0;
               end
            end else if (s_q.ctrl.linear &&
                         slot == s_q.rx_slot + SLOT_ONE) begin
               s_d.rx_lin   = {s_q.lin_hi, rx_byte};
               s_d.rx_valid = 1'b1;
               s_d.rx_voice = 1'b0;
            end
         end
         // Transmit side, full bytes only
         if (tslot == 7'h00 && pos[2:0] == 3'h0) begin
            s_d.tx_word = s_q.ctrl.linear ? tx_code_in :
                          {tx_comp, sig_byte};
         end
         s_d.tx_data = s_d.tx_word[4'hF - tsel];
         s_d.tx_en   = ~s_q.ctrl.gci_mode &
                       ((tslot == 7'h00 & channel_active_in) |
                        (tslot == SLOT_ONE &
                         ((s_q.ctrl.linear & channel_active_in) |
                          (s_q.ctrl.highway_signaling_enable &
                           ~s_q.ctrl.linear))));
      end
      s_d.tx_en = s_d.tx_en & ~s_q.ctrl.gci_mode;

      // Configuration port
      if (cfg_req_in.wr) begin
         case (cfg_req_in.addr)
            ADDR_CTRL:    s_d.ctrl    = cfg_req_in.wdata;
            ADDR_RX_SLOT: s_d.rx_slot = cfg_req_in.wdata[6:0];
            ADDR_TX_SLOT: s_d.tx_slot = cfg_req_in.wdata[6:0];
            default:      s_d.ctrl    = s_d.ctrl;
         endcase
      end
      if (cfg_req_in.rd) begin
         case (cfg_req_in.addr)
            ADDR_CTRL:    s_d.rdata = s_q.ctrl;
            ADDR_RX_SLOT: s_d.rdata = {1'b0, s_q.rx_slot};
            ADDR_TX_SLOT: s_d.rdata = {1'b0, s_q.tx_slot};
            ADDR_STATUS:  s_d.rdata = {5'h00, s_q.framed, s_q.prev_two,
                                       s_q.robbed};
            ADDR_RX_LO:   s_d.rdata = s_q.rx_lin[7:0];
            ADDR_RX_HI:   s_d.rdata = s_q.rx_lin[15:8];
            default:      s_d.rdata = 8'h00;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // State register
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         s_q          <= '0;
         s_q.ctrl     <= CTRL_RESET;
         s_q.rx_slot  <= SLOT_RESET;
         s_q.tx_slot  <= SLOT_RESET;
         s_q.fs_len   <= FS_IDLE;
      end else begin
         s_q <= s_d;
      end
   end

   assign cfg_rdata_out             = s_q.rdata;
   assign dsp_clk_out               = s_q.dsp_clk;
   assign tx_data_out               = s_q.tx_data;
   assign tx_enable_out             = s_q.tx_en;
   assign rx_linear_out             = s_q.rx_lin;
   assign rx_valid_out              = s_q.rx_valid;
   assign rx_voice_sel_out          = s_q.rx_voice;
   assign monitor_byte_out          = s_q.mon;
   assign monitor_strobe_out        = s_q.mon_stb;
   assign signal_control_byte_out   = s_q.scb;
   assign signal_control_strobe_out = s_q.sc_stb;
   assign robbed_frame_out          = s_q.robbed;

   ////////////////////////////////////////////////////////////////////////
   // Checks
   AST_RESET_CLEAR: assert property (@(posedge clk_in)
      rst_in |=> (s_q.ctrl == CTRL_RESET && !s_q.tx_en))
      else $error("enables not cleared by reset");

   AST_HALF_RATE: assert property (@(posedge clk_in) disable iff (rst_in)
      (fall && !start && s_q.ctrl.double_clock_enable &&
       !s_q.ctrl.gci_mode && !s_q.phase)
      |=> $stable(s_q.bit_cnt))
      else $error("double clock shifted on a skipped edge");

   AST_FULL_RATE: assert property (@(posedge clk_in) disable iff (rst_in)
      (fall && !start && s_q.framed && !s_q.ctrl.double_clock_enable &&
       s_q.bit_cnt != CNT_MAX)
      |=> s_q.bit_cnt == $past(s_q.bit_cnt) + 10'h001)
      else $error("bit counter missed a falling edge");

   AST_SLOT_ZERO: assert property (@(posedge clk_in) disable iff (rst_in)
      start |=> (s_q.bit_cnt == 10'h000 && s_q.framed))
      else $error("frame sync did not restart slot 0");

   AST_ROBBED_CAUSE: assert property (@(posedge clk_in) disable iff (rst_in)
      $rose(s_q.robbed) |-> (s_q.prev_two && !$past(s_q.prev_two) &&
                             $past(s_q.ctrl.mu_law)))
      else $error("robbed frame without a new two-clock sync");

   AST_RX_PULSE: assert property (@(posedge clk_in) disable iff (rst_in)
      s_q.rx_valid |=> !s_q.rx_valid)
      else $error("receive valid longer than one cycle");

   AST_GCI_NO_TX: assert property (@(posedge clk_in) disable iff (rst_in)
      (s_q.ctrl.gci_mode && $past(s_q.ctrl.gci_mode, 2)) |-> !s_q.tx_en)
      else $error("highway driven in GCI mode");

   AST_DSP_CLOCK: assert property (@(posedge clk_in) disable iff (rst_in)
      $past(s_q.ctrl.master_clock_source_sel) |->
      s_q.dsp_clk == $past(bit_clk_in))
      else $error("DSP clock not taken from bit clock");

   AST_RDATA_WINDOW: assert property (@(posedge clk_in) disable iff (rst_in)
      !$past(cfg_req_in.rd) |-> s_q.rdata == 8'h00)
      else $error("read data outside its cycle");

   COV_ROBBED: cover property (@(posedge clk_in) disable iff (rst_in)
      s_q.robbed && s_q.rx_valid);
   COV_LINEAR: cover property (@(posedge clk_in) disable iff (rst_in)
      s_q.ctrl.linear && s_q.rx_valid);
   COV_GCI_MON: cover property (@(posedge clk_in) disable iff (rst_in)
      s_q.mon_stb ##[1:64] s_q.sc_stb);
   COV_SIG_SLOT: cover property (@(posedge clk_in) disable iff (rst_in)
      s_q.tx_en && s_q.ctrl.highway_signaling_enable && !channel_active_in);

endmodule : pcm_highway_coder

/* bench/highway_far_end.sv */
// Far-end highway model: bit clock, frame syncs and receive data for a frame.
// Assumes the coder samples every pin on clk_in; bit clock rests low between
// frames and each bit clock period is eight clk_in cycles.
`timescale 1ns/10ps
module highway_far_end (
   // Clock
   input  wire logic clk_in,
   // Highway
   output logic      bit_clk_out,
   output logic      pcm_sync_out,
   output logic      gci_sync_out,
   output logic      data_out,
   input  wire logic tx_data_in,
   input  wire logic tx_enable_in
);
   logic [255:0] tx_cap;
   logic [255:0] en_cap;

   initial begin
      bit_clk_out = 1'b0;
      pcm_sync_out = 1'b0;
      gci_sync_out = 1'b0;
      data_out = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////
   // One frame; tx is captured just before each fall, so index k-1 holds
   // what the coder drove for the previous bit position
   task automatic run_frame(input logic [127:0] bits, input int nbits,
                            input int sync_len, input bit gci, input bit dbl);
      int k;
      int b;
      for (k = 0; k < (dbl ? 2 : 1) * nbits + 4; k++) begin
         b = dbl ? k / 2 : k;
         @(posedge clk_in);
         bit_clk_out <= 1'b1;
         // Each bit held over two bit clocks in double clock mode
         data_out <= (b < nbits) ? bits[127 - b] : ~data_out;
         // Sync high for sync_len falls marks slot 0
         pcm_sync_out <= !gci && (k < sync_len);
         gci_sync_out <= gci && (k < sync_len);
         repeat (3) @(posedge clk_in);
         bit_clk_out <= 1'b0;
         if (k > 0) begin
            tx_cap[k - 1] <= tx_data_in;
            en_cap[k - 1] <= tx_enable_in;
         end
         repeat (4) @(posedge clk_in);
      end
      data_out <= ~data_out;
   endtask : run_frame
endmodule : highway_far_end

/* bench/testbench.sv */
// Self-checking bench for the highway coder with a far-end highway model.
// Assumes the coder's configuration map and timing as handed over.
`timescale 1ns/10ps
module testbench;
   import pcm_highway_pkg::*;
   logic        clk_in, rst_in, mclk_in, bit_clk_in, dsp_clk_out;
   cfg_req_t    cfg_req_in;
   logic [7:0]  cfg_rdata_out, monitor_byte_out, signal_control_byte_out;
   logic        pcm_frame_sync_in, gci_frame_sync_in, line, tx_data_out;
   logic        gci_chan_sel_low_in, gci_chan_sel_high_in, tx_enable_out;
   logic [15:0] tx_code_in, rx_linear_out, rx_last, got;
   logic        channel_active_in, detector_input_first_in, rx_valid_out;
   logic        detector_input_second_in, detector_input_muxed_in;
   logic        clock_failure_flag_in, rx_voice_sel_out, monitor_strobe_out;
   logic        signal_control_strobe_out, robbed_frame_out;
   logic [7:0]  mon_last, ctl_last, v;
   int          failures, total_checks, cycles, rx_seen, dsp_high, n0, i;
   logic [7:0]  rb_ctrl [4] = '{8'h0C, 8'h0C, 8'h0C, 8'h04};
   int          rb_len [4] = '{2, 2, 1, 2};
   logic        rb_exp [4] = '{1'b1, 1'b0, 1'b0, 1'b0};
   logic [7:0]  tx_ctrl [4] = '{8'h0A, 8'h8A, 8'h00, 8'h10};
   logic [15:0] tx_word [4] = '{16'h00A5, 16'h00A5, 16'h00A5, 16'h1234};
   logic [15:0] tx_exp [4] = '{16'h0084, 16'hA5C4, 16'hF000, 16'h1234};
   logic [1:0]  tx_en [4] = '{2'b01, 2'b11, 2'b10, 2'b11};
   logic        tx_act [4] = '{1'b0, 1'b1, 1'b1, 1'b1};

   pcm_highway_coder pcm_highway_coder_inst (.clk_in, .rst_in, .cfg_req_in,
      .cfg_rdata_out, .bit_clk_in, .mclk_in, .dsp_clk_out, .pcm_frame_sync_in,
      .pcm_rx_data_in(line), .gci_frame_sync_in, .downstream_line_in(line),
      .gci_chan_sel_low_in, .gci_chan_sel_high_in, .tx_data_out,
      .tx_enable_out, .tx_code_in, .channel_active_in,
      .detector_input_first_in, .detector_input_second_in,
      .detector_input_muxed_in, .clock_failure_flag_in, .rx_linear_out,
      .rx_valid_out, .rx_voice_sel_out, .monitor_byte_out,
      .monitor_strobe_out, .signal_control_byte_out,
      .signal_control_strobe_out, .robbed_frame_out);

   highway_far_end highway_far_end_inst (.clk_in, .bit_clk_out(bit_clk_in),
      .pcm_sync_out(pcm_frame_sync_in), .gci_sync_out(gci_frame_sync_in),
      .data_out(line), .tx_data_in(tx_data_out), .tx_enable_in(tx_enable_out));

   ////////////////////////////////////////////////////////////////////////
   always #4 clk_in = ~clk_in;

   always @(posedge clk_in) begin
      cycles <= cycles + 1;
      if (rx_valid_out === 1'b1) begin
         rx_last <= rx_linear_out;
         rx_seen <= rx_seen + 1;
      end
      if (monitor_strobe_out === 1'b1) mon_last <= monitor_byte_out;
      if (signal_control_strobe_out === 1'b1) ctl_last <= signal_control_byte_out;
      if (dsp_clk_out === 1'b1) dsp_high <= dsp_high + 1;
      if (cycles == 60000) begin
         failures = failures + 1;
         final_report();
      end
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [15:0] seen, input logic [15:0] exp,
                        input string what);
      total_checks = total_checks + 1;
      if (seen !== exp) begin
         failures = failures + 1;
         $display("unexpected at %0t: %s got %h want %h", $time, what, seen, exp);
      end
   endtask : check

   task automatic cfg_wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_in);
      cfg_req_in <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk_in);
      cfg_req_in <= '0;
   endtask : cfg_wr

   task automatic cfg_rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_in);
      cfg_req_in <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk_in);
      cfg_req_in <= '0;
      #1 d = cfg_rdata_out;
   endtask : cfg_rd

   task automatic frame(input logic [127:0] b, input int n, input int sl,
                        input bit g, input bit d);
      n0 = rx_seen;
      highway_far_end_inst.run_frame(b, n, sl, g, d);
      repeat (4) @(posedge clk_in);
   endtask : frame

   function automatic logic [15:0] mu_exp(input logic [7:0] c, input bit half);
      logic [7:0]  u;
      logic [15:0] t;
      u = ~c;
      t = {9'h000, u[3:0], 3'h0} + 16'h0084;
      if (half) t = {9'h000, u[3:1], 4'h0} + 16'h0088;
      t = t << u[6:4];
      return u[7] ? 16'h0084 - t : t - 16'h0084;
   endfunction : mu_exp

   function automatic logic [15:0] a_exp(input logic [7:0] c);
      logic [7:0]  a;
      logic [15:0] t;
      a = c ^ 8'h55;
      t = {8'h00, a[3:0], 4'h0};
      if (a[6:4] == 3'h0) t = t + 16'h0008;
      else t = (t + 16'h0108) << (a[6:4] - 3'h1);
      return a[7] ? t : 16'h0000 - t;
   endfunction : a_exp

   task automatic final_report;
      $display("checks %0d mismatches %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : final_report

   ////////////////////////////////////////////////////////////////////////
   initial begin
      clk_in = 1'b0;
      rst_in = 1'b1;
      cfg_req_in = '0;
      tx_code_in = 16'h0000;
      {channel_active_in, gci_chan_sel_low_in, gci_chan_sel_high_in} = 3'h0;
      {detector_input_first_in, detector_input_second_in} = 2'b10;
      {detector_input_muxed_in, clock_failure_flag_in, mclk_in} = 3'b110;
      {failures, total_checks, cycles, rx_seen, dsp_high} = '0;
      repeat (20) @(posedge clk_in);
      rst_in <= 1'b0;
      cfg_rd(ADDR_CTRL, v);
      check(v, 16'h0000, "ctrl reset");
      cfg_rd(8'h3F, v);
      check(v, 16'h0000, "unmapped read");
      cfg_wr(ADDR_CTRL, 8'h08);
      cfg_wr(ADDR_RX_SLOT, 8'h02);
      cfg_rd(ADDR_CTRL, v);
      check(v, 16'h0008, "ctrl readback");
      frame({24'h00FFC3, 104'h0}, 32, 1, 0, 0);
      check(rx_seen - n0, 16'h0001, "one sample");
      check(rx_last, mu_exp(8'hC3, 0), "mu full byte");
      for (i = 0; i < 4; i++) begin
         cfg_wr(ADDR_CTRL, rb_ctrl[i]);
         frame({24'h00FFC3, 104'h0}, 32, rb_len[i], 0, 0);
         check(robbed_frame_out, rb_exp[i], "robbed flag");
         check(rx_last, (i == 3) ? a_exp(8'hC3) : mu_exp(8'hC3, rb_exp[i]),
               "robbed expand");
      end
      cfg_wr(ADDR_CTRL, 8'h10);
      cfg_wr(ADDR_RX_SLOT, 8'h01);
      frame({24'h008001, 104'h0}, 32, 1, 0, 0);
      check(rx_last, 16'h8001, "linear rx");
      cfg_wr(ADDR_CTRL, 8'h09);
      cfg_wr(ADDR_RX_SLOT, 8'h02);
      frame({24'h00FFC3, 104'h0}, 32, 1, 0, 1);
      check(rx_last, mu_exp(8'hC3, 0), "double clock rx");
      cfg_wr(ADDR_TX_SLOT, 8'h01);
      // Signaling cases stay companded
      for (i = 0; i < 4; i++) begin
         cfg_wr(ADDR_CTRL, tx_ctrl[i]);
         tx_code_in <= tx_word[i];
         channel_active_in <= tx_act[i];
         frame(128'h0, 32, 1, 0, 0);
         for (n0 = 0; n0 < 16; n0++) got[15 - n0] = highway_far_end_inst.tx_cap[8 + n0];
         check(got & {{8{tx_en[i][1]}}, {8{tx_en[i][0]}}}, tx_exp[i],
               "tx bytes");
         check({highway_far_end_inst.en_cap[7], highway_far_end_inst.en_cap[8],
                highway_far_end_inst.en_cap[16], highway_far_end_inst.en_cap[24]},
               {2'b00, tx_en[i], 1'b0}, "tx enable");
      end
      cfg_wr(ADDR_CTRL, 8'h49);
      gci_chan_sel_high_in <= 1'b1;
      frame({64'h0, 32'hC3115AA6, 32'h0}, 96, 1, 1, 0);
      check(rx_seen - n0, 16'h0002, "gci voice count");
      check(rx_last, mu_exp(8'h11, 0), "gci voice two");
      check(rx_voice_sel_out, 16'h0001, "voice select");
      check(mon_last, 16'h005A, "monitor byte");
      check(ctl_last, 16'h00A6, "control byte");
      cfg_wr(ADDR_CTRL, 8'h20);
      n0 = dsp_high;
      highway_far_end_inst.run_frame(128'h0, 8, 1, 0, 0);
      check(dsp_high > n0, 16'h0001, "dsp clock from bit clock");
      cfg_wr(ADDR_CTRL, 8'h00);
      n0 = dsp_high;
      highway_far_end_inst.run_frame(128'h0, 8, 1, 0, 0);
      check(dsp_high - n0, 16'h0000, "dsp clock from mclk");
      final_report();
   end
endmodule : testbench
